// ### port_gpio_defs.vh
// constants and register map of the serial-shared port and plain gpio port
`ifndef PORT_GPIO_DEFS_VH
`define PORT_GPIO_DEFS_VH

// register byte offsets
`define OFS_PLAIN_DIR       12'h000
`define OFS_PLAIN_DATA      12'h004
`define OFS_SHARED_DIR      12'h008
`define OFS_SHARED_DATA     12'h00c
`define OFS_PIN_MODE        12'h010
`define OFS_SERIAL_CTRL     12'h014
`define OFS_PIN_FUNC        12'h018
`define ADDR_W              12

// widths
`define PLAIN_W             8
`define SHARED_W            5

// reset values
`define PLAIN_DIR_RST       8'h00
`define PLAIN_DATA_RST      8'h00
`define SHARED_DIR_RST      5'h00
`define SHARED_DATA_RST     5'h00
`define PIN_MODE_RST        1'b0
`define SERIAL_CTRL_RST     4'h0

// fixed read values
`define DIR_READ_VAL        32'h0000_0000
`define SHARED_RSVD_ONES    3'h7
`define ZERO_WORD           32'h0000_0000

// pin mode register field
`define PMODE_TXSEL_BIT     1

// serial control register fields
`define SCTL_RXEN_BIT       0
`define SCTL_CKLO_BIT       1
`define SCTL_CKHI_BIT       2
`define SCTL_COM_BIT        3
`define SCTL_W              4

// shared pin indices
`define PIN_SCK             0
`define PIN_RXD             1
`define PIN_TXD             2

// pin function status fields
`define PFUNC_GPIO0_BIT     0
`define PFUNC_SCKO_BIT      1
`define PFUNC_SCKI_BIT      2
`define PFUNC_RXD_BIT       3
`define PFUNC_TXD_BIT       4
`define PFUNC_W             5

`endif

// ### pin_sync.v
// two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/100ps
module pin_sync #(
  parameter W = 8
) (
  input  wire         core_clk_i,
  input  wire         nrst_i,
  input  wire [W-1:0] async_i,
  output wire [W-1:0] sync_o
);

  reg [W-1:0] meta_q;
  reg [W-1:0] sync_q;

  // first stage feeds only the second
  always @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      meta_q <= {W{1'b0}};
      sync_q <= {W{1'b0}};
    end else begin
      meta_q <= async_i;
      sync_q <= meta_q;
    end
  end

  assign sync_o = sync_q;

endmodule // pin_sync

// ### port_gpio.v
// serial-shared port and plain gpio port with apb register access
//
// Local design decisions: the placing of the registers and the APB interface to the registers.
`timescale 1ns/100ps
`include "port_gpio_defs.vh"
module port_gpio (
  input  wire        core_clk_i,
  input  wire        nrst_i,
  // apb slave
  input  wire        psel_i,
  input  wire        penable_i,
  input  wire        pwrite_i,
  input  wire [31:0] paddr_i,
  input  wire [31:0] pwdata_i,
  input  wire [3:0]  pstrb_i,
  output wire        pready_o,
  output wire [31:0] prdata_o,
  output wire        pslverr_o,
  // plain port pins
  input  wire [7:0]  plain_pin_i,
  output wire [7:0]  plain_pin_o,
  output wire [7:0]  plain_pin_oe_o,
  // serial-shared port pins
  input  wire [4:0]  shared_pin_i,
  output wire [4:0]  shared_pin_o,
  output wire [4:0]  shared_pin_oe_o,
  // serial interface side
  input  wire        ser_txd_i,
  input  wire        ser_sck_out_i,
  output wire        ser_rxd_o,
  output wire        ser_sck_in_o
);

  ////////////////////////////////////////////////////////////////////////////
  // state
  // registers written over apb; reset clears every one of them
  // serial control and pin mode bits are held here as well
  // widths stay fixed: eight plain pins, five shared pins
  // direction bits are write-only and read back as zero
  // software keeps its own shadow, no read-modify-write
  // pin drives and serial inputs pass one more flop,
  // so each output of the block leaves a flip-flop;
  // the price is one cycle from register write to pin

  reg [`PLAIN_W-1:0]  plain_port_direction_q;
  reg [`PLAIN_W-1:0]  plain_port_data_q;
  reg [`SHARED_W-1:0] shared_port_direction_q;
  reg [`SHARED_W-1:0] shared_port_data_q;
  reg                 pin_mode_select_reg_q;
  reg [`SCTL_W-1:0]   serial_control_reg_q;

  reg                 pready_q;
  reg [31:0]          prdata_q;
  reg                 pslverr_q;

  reg [`PLAIN_W-1:0]  plain_out_q;
  reg [`PLAIN_W-1:0]  plain_oe_q;
  reg [`SHARED_W-1:0] shared_out_q;
  reg [`SHARED_W-1:0] shared_oe_q;
  reg                 ser_rxd_q;
  reg                 ser_sck_in_q;

  wire [`PLAIN_W-1:0]  plain_sync;
  wire [`SHARED_W-1:0] shared_sync;

  ////////////////////////////////////////////////////////////////////////////
  // pin input synchronisers
  // pin levels come from outside the clock domain
  // two flops each before any logic looks at them
  // the first stage feeds nothing but the second
  // both stages clear to low at reset
  // a read of an input pin lags the pin by two cycles

  // plain port pin levels
  pin_sync #(
    .W (`PLAIN_W)
  ) u_plain_sync (
    .core_clk_i (core_clk_i),
    .nrst_i     (nrst_i),
    .async_i    (plain_pin_i),
    .sync_o     (plain_sync)
  );

  // shared port pin levels
  pin_sync #(
    .W (`SHARED_W)
  ) u_shared_sync (
    .core_clk_i (core_clk_i),
    .nrst_i     (nrst_i),
    .async_i    (shared_pin_i),
    .sync_o     (shared_sync)
  );

  ////////////////////////////////////////////////////////////////////////////
  // serial pin function decode
  // serial control bits outrank the direction bits
  // pins 4 and 3: direction bit alone
  // pin 2: transmit select forces serial transmit out
  // pin 1: receive enable forces an input for receive
  // pin 0: clock enable high gives a clock input,
  //   else clock enable low or mode bit a clock output,
  //   else the direction bit
  // a pin taken as serial input shows oe low, out low
  // transmit and clock levels come from this clock,
  // so they need no synchroniser
  // the function status register shows this decode
  // so software can see which pins the serial side holds

  wire txsel    = pin_mode_select_reg_q;
  wire rx_en    = serial_control_reg_q[`SCTL_RXEN_BIT];
  wire cke_low  = serial_control_reg_q[`SCTL_CKLO_BIT];
  wire cke_high = serial_control_reg_q[`SCTL_CKHI_BIT];
  wire com_mode = serial_control_reg_q[`SCTL_COM_BIT];

  // pin 0 by clock enables, then mode bit, then direction
  wire sck_in   = cke_high;
  wire sck_out  = !cke_high && (cke_low || com_mode);
  wire sck_gpio = !cke_high && !cke_low && !com_mode;

  // effective output enable and value of each shared pin
  reg [`SHARED_W-1:0] shared_oe_d;
  reg [`SHARED_W-1:0] shared_out_d;

  always @* begin
    // pins 4 and 3 plain direction
    shared_oe_d  = shared_port_direction_q;
    shared_out_d = shared_port_data_q;
    // pin 2: transmit select wins over direction
    if (txsel) begin
      shared_oe_d[`PIN_TXD]  = 1'b1;
      shared_out_d[`PIN_TXD] = ser_txd_i;
    end
    // pin 1: receive enable makes it an input
    if (rx_en) begin
      shared_oe_d[`PIN_RXD]  = 1'b0;
      shared_out_d[`PIN_RXD] = 1'b0;
    end
    // pin 0: serial clock input or output
    if (sck_in) begin
      shared_oe_d[`PIN_SCK]  = 1'b0;
      shared_out_d[`PIN_SCK] = 1'b0;
    end else if (sck_out) begin
      shared_oe_d[`PIN_SCK]  = 1'b1;
      shared_out_d[`PIN_SCK] = ser_sck_out_i;
    end
  end

  // shared pins acting as general outputs
  wire [`SHARED_W-1:0] shared_gpio_out;
  assign shared_gpio_out = shared_port_direction_q &
                           {1'b1, 1'b1, !txsel, !rx_en, sck_gpio};

  ////////////////////////////////////////////////////////////////////////////
  // pin output registers
  // every drive and enable leaves a flop, no glitch on pins
  // output value and enable change on the same edge
  // so a pin never turns on with stale data
  // plain pins copy direction and data bits directly
  // reset releases all pins: oe low means input
  // serial inputs read zero while their function is off
  // received level passes the synchroniser first

  // every pin drive comes from a flop
  always @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      plain_out_q  <= `PLAIN_DATA_RST;
      plain_oe_q   <= `PLAIN_DIR_RST;
      shared_out_q <= `SHARED_DATA_RST;
      shared_oe_q  <= `SHARED_DIR_RST;
      ser_rxd_q    <= 1'b0;
      ser_sck_in_q <= 1'b0;
    end else begin
      plain_out_q  <= plain_port_data_q;
      plain_oe_q   <= plain_port_direction_q;
      shared_out_q <= shared_out_d;
      shared_oe_q  <= shared_oe_d;
      ser_rxd_q    <= rx_en & shared_sync[`PIN_RXD];
      ser_sck_in_q <= sck_in & shared_sync[`PIN_SCK];
    end
  end

  assign plain_pin_o     = plain_out_q;
  assign plain_pin_oe_o  = plain_oe_q;
  assign shared_pin_o    = shared_out_q;
  assign shared_pin_oe_o = shared_oe_q;
  assign ser_rxd_o       = ser_rxd_q;
  assign ser_sck_in_o    = ser_sck_in_q;

  ////////////////////////////////////////////////////////////////////////////
  // apb decode
  // one aligned word per register, data in the low bits
  // 000 plain direction, 004 plain data
  // 008 shared direction, 00c shared data
  // 010 pin mode, 014 serial control
  // 018 pin function status, read only
  // upper address bits must be zero to hit
  // a miss or a status write gets a slave error
  // a write with the low byte strobe off is dropped quietly
  // no other strobe bit matters, the high bytes are unused

  wire [`ADDR_W-1:0] addr = paddr_i[`ADDR_W-1:0];
  wire               hi_zero = (paddr_i[31:`ADDR_W] == 20'h00000);

  wire hit_plain_dir   = hi_zero && (addr == `OFS_PLAIN_DIR);
  wire hit_plain_data  = hi_zero && (addr == `OFS_PLAIN_DATA);
  wire hit_shared_dir  = hi_zero && (addr == `OFS_SHARED_DIR);
  wire hit_shared_data = hi_zero && (addr == `OFS_SHARED_DATA);
  wire hit_pin_mode    = hi_zero && (addr == `OFS_PIN_MODE);
  wire hit_serial_ctrl = hi_zero && (addr == `OFS_SERIAL_CTRL);
  wire hit_pin_func    = hi_zero && (addr == `OFS_PIN_FUNC);

  wire hit_any = hit_plain_dir | hit_plain_data | hit_shared_dir |
                 hit_shared_data | hit_pin_mode | hit_serial_ctrl |
                 hit_pin_func;

  // the status register takes no writes
  wire bad_access = !hit_any || (pwrite_i && hit_pin_func);

  // first access cycle prepares the answer, second one completes it
  wire acc_first = psel_i && penable_i && !pready_q;
  wire acc_done  = psel_i && penable_i && pready_q;
  wire wr_ok     = acc_done && pwrite_i && !pslverr_q && pstrb_i[0];

  ////////////////////////////////////////////////////////////////////////////
  // read data mux
  // direction registers answer zero, never their content
  // data registers merge stored bits and pin levels:
  //   stored bit where the pin is a general output
  //   synchronised level everywhere else
  // a pin held by the serial side reads its level
  // shared data bits 7 to 5 read as ones
  // unmapped reads answer zero
  // the mux is sampled once, in the first access cycle
  // the read answer stands one cycle with pready

  reg [31:0] rdata_d;

  always @* begin
    rdata_d = `ZERO_WORD;
    if (hit_plain_dir || hit_shared_dir) begin
      rdata_d = `DIR_READ_VAL;
    end else if (hit_plain_data) begin
      rdata_d[`PLAIN_W-1:0] = (plain_port_data_q & plain_port_direction_q) |
                              (plain_sync & ~plain_port_direction_q);
    end else if (hit_shared_data) begin
      rdata_d[`SHARED_W-1:0] = (shared_port_data_q & shared_gpio_out) |
                               (shared_sync & ~shared_gpio_out);
      rdata_d[`PLAIN_W-1:`SHARED_W] = `SHARED_RSVD_ONES;
    end else if (hit_pin_mode) begin
      rdata_d[`PMODE_TXSEL_BIT] = pin_mode_select_reg_q;
    end else if (hit_serial_ctrl) begin
      rdata_d[`SCTL_W-1:0] = serial_control_reg_q;
    end else if (hit_pin_func) begin
      rdata_d[`PFUNC_GPIO0_BIT] = sck_gpio;
      rdata_d[`PFUNC_SCKO_BIT]  = sck_out;
      rdata_d[`PFUNC_SCKI_BIT]  = sck_in;
      rdata_d[`PFUNC_RXD_BIT]   = rx_en;
      rdata_d[`PFUNC_TXD_BIT]   = txsel;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb handshake
  // cycle 0: setup, psel high, penable low
  // cycle 1: first access cycle, answer prepared
  // cycle 2: pready high, read data and error stand
  // a write takes effect at the end of cycle 2
  // pready stands one cycle only, then drops
  // back to back transfers need no idle cycle
  // read data is zero outside the answer cycle
  // the slave never stretches beyond one wait state
  // nothing here depends on the read data of a write

  // one wait state, answer registered
  always @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pready_q  <= 1'b0;
      prdata_q  <= `ZERO_WORD;
      pslverr_q <= 1'b0;
    end else if (acc_first) begin
      pready_q  <= 1'b1;
      pslverr_q <= bad_access;
      prdata_q  <= (pwrite_i || bad_access) ? `ZERO_WORD : rdata_d;
    end else begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= `ZERO_WORD;
    end
  end

  assign pready_o  = pready_q;
  assign prdata_o  = prdata_q;
  assign pslverr_o = pslverr_q;

  ////////////////////////////////////////////////////////////////////////////
  // register writes
  // writes land only at the edge where pready is seen
  // an errored transfer leaves every register alone
  // only the low byte of write data is used
  // bits above each register's width are dropped
  // each register decodes its own offset
  // reads never change a register
  // a new write shows on the pins one cycle later

  // plain port direction and data
  always @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      plain_port_direction_q <= `PLAIN_DIR_RST;
      plain_port_data_q      <= `PLAIN_DATA_RST;
    end else if (wr_ok) begin
      if (hit_plain_dir) begin
        plain_port_direction_q <= pwdata_i[`PLAIN_W-1:0];
      end
      if (hit_plain_data) begin
        plain_port_data_q <= pwdata_i[`PLAIN_W-1:0];
      end
    end
  end

  // shared port direction and data
  always @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      shared_port_direction_q <= `SHARED_DIR_RST;
      shared_port_data_q      <= `SHARED_DATA_RST;
    end else if (wr_ok) begin
      if (hit_shared_dir) begin
        shared_port_direction_q <= pwdata_i[`SHARED_W-1:0];
      end
      if (hit_shared_data) begin
        shared_port_data_q <= pwdata_i[`SHARED_W-1:0];
      end
    end
  end

  // pin mode and serial control bits
  always @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pin_mode_select_reg_q <= `PIN_MODE_RST;
      serial_control_reg_q  <= `SERIAL_CTRL_RST;
    end else if (wr_ok) begin
      if (hit_pin_mode) begin
        pin_mode_select_reg_q <= pwdata_i[`PMODE_TXSEL_BIT];
      end
      if (hit_serial_ctrl) begin
        serial_control_reg_q <= pwdata_i[`SCTL_W-1:0];
      end
    end
  end

endmodule // port_gpio

// ### pin_board.sv
// board model for the port pins
`timescale 1ns/100ps
module pin_board (
  input  wire logic [7:0] p_oe_i,
  input  wire logic [7:0] p_o_i,
  input  wire logic [7:0] p_ext_i,
  input  wire logic [4:0] s_oe_i,
  input  wire logic [4:0] s_o_i,
  input  wire logic [4:0] s_ext_i,
  output wire logic [7:0] p_lvl_o,
  output wire logic [4:0] s_lvl_o
);
  // a driven pin shows the device level, a released one the board level
  assign p_lvl_o = (p_oe_i & p_o_i) | (~p_oe_i & p_ext_i);
  assign s_lvl_o = (s_oe_i & s_o_i) | (~s_oe_i & s_ext_i);
endmodule // pin_board

// ### port_gpio_checker.sv
// assertion checker for the port block
`timescale 1ns/100ps
module port_gpio_checker (
  input wire logic        core_clk_i,
  input wire logic        nrst_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [31:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0]  pstrb_i,
  input wire logic        pready_o,
  input wire logic [31:0] prdata_o,
  input wire logic [7:0]  plain_pin_o,
  input wire logic [7:0]  plain_pin_oe_o,
  input wire logic [4:0]  shared_pin_oe_o
);
  logic [7:0] dir_q, dat_q;
  logic [4:0] sdir_q;
  logic [3:0] ctl_q;
  logic       txs_q;
  logic [1:0] quiet_q;
  wire hit = psel_i & penable_i & pready_o & (paddr_i[31:12] == 20'h0);
  wire wr  = hit & pwrite_i & pstrb_i[0];
  wire rd  = hit & !pwrite_i;
  wire [11:0] ofs = paddr_i[11:0];
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);
  ////////////////////////////////////////////////////////////////////////////////
  // register shadow and cycles since the last write
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      {dir_q, dat_q, sdir_q, ctl_q, txs_q} <= 26'h0;
      quiet_q <= 2'h3;
    end else begin
      quiet_q <= wr ? 2'h0 : (quiet_q == 2'h3 ? 2'h3 : quiet_q + 2'h1);
      if (wr && ofs == 12'h000) dir_q <= pwdata_i[7:0];
      if (wr && ofs == 12'h004) dat_q <= pwdata_i[7:0];
      if (wr && ofs == 12'h008) sdir_q <= pwdata_i[4:0];
      if (wr && ofs == 12'h010) txs_q <= pwdata_i[1];
      if (wr && ofs == 12'h014) ctl_q <= pwdata_i[3:0];
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  sequence s_setup; psel_i && !penable_i; endsequence
  sequence s_access; psel_i && penable_i; endsequence
  property p_ack; s_setup ##1 s_access |-> ##1 pready_o ##1 !pready_o; endproperty
  property p_plain_pins;
    quiet_q == 2'h3 |-> plain_pin_oe_o == dir_q && plain_pin_o == dat_q;
  endproperty
  property p_upper; quiet_q == 2'h3 |-> shared_pin_oe_o[4:3] == sdir_q[4:3]; endproperty
  property p_txd; quiet_q == 2'h3 |-> shared_pin_oe_o[2] == (txs_q | sdir_q[2]); endproperty
  property p_rxd; quiet_q == 2'h3 |-> shared_pin_oe_o[1] == (!ctl_q[0] & sdir_q[1]); endproperty
  property p_sck;
    quiet_q == 2'h3 |-> shared_pin_oe_o[0] == (!ctl_q[2] & (ctl_q[1] | ctl_q[3] | sdir_q[0]));
  endproperty
  property p_reset;
    $rose(nrst_i) |-> plain_pin_oe_o == 8'h00 && shared_pin_oe_o == 5'h00 && plain_pin_o == 8'h00;
  endproperty
  property p_dir_read; rd && (ofs == 12'h000 || ofs == 12'h008) |-> prdata_o == 32'h0; endproperty
  property p_plain_read;
    rd && ofs == 12'h004 |-> (prdata_o[7:0] & dir_q) == (dat_q & dir_q) && prdata_o[31:8] == 24'h0;
  endproperty
  property p_shared_read; rd && ofs == 12'h00c |-> prdata_o[31:5] == 27'h7; endproperty
  a_ack: assert property (p_ack) else $error("apb answer late or long");
  a_plain_pins: assert property (p_plain_pins)
    else $error("plain pins differ from registers");
  a_upper: assert property (p_upper) else $error("shared pins 4:3 wrong");
  a_txd: assert property (p_txd) else $error("shared pin 2 enable wrong");
  a_rxd: assert property (p_rxd) else $error("shared pin 1 enable wrong");
  a_sck: assert property (p_sck) else $error("shared pin 0 enable wrong");
  a_reset: assert property (p_reset) else $error("pins not inputs after reset");
  a_dir_read: assert property (p_dir_read) else $error("direction read not zero");
  a_plain_read: assert property (p_plain_read) else $error("plain read wrong");
  a_shared_read: assert property (p_shared_read) else $error("shared read wrong");
endmodule // port_gpio_checker
bind port_gpio port_gpio_checker u_chk (
  .core_clk_i(core_clk_i), .nrst_i(nrst_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i),
  .pready_o(pready_o), .prdata_o(prdata_o), .plain_pin_o(plain_pin_o),
  .plain_pin_oe_o(plain_pin_oe_o), .shared_pin_oe_o(shared_pin_oe_o)
);

// ### serial_shared_port_and_gpio_port_tb.sv
// self-checking bench for the serial-shared and plain port block
`timescale 1ns/100ps
module serial_shared_port_and_gpio_port_tb;
  logic        core_clk_i = 1'b0, nrst_i = 1'b0;
  logic        psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
  logic [31:0] paddr_i = 32'h0, pwdata_i = 32'h0, prdata_o, rd;
  logic [3:0]  pstrb_i = 4'hf;
  logic        ser_txd_i = 1'b0, ser_sck_out_i = 1'b0, err;
  logic [7:0]  p_ext = 8'h00, plain_pin_i, plain_pin_o, plain_pin_oe_o;
  logic [4:0]  s_ext = 5'h00, shared_pin_i, shared_pin_o, shared_pin_oe_o;
  logic        pready_o, pslverr_o, ser_rxd_o, ser_sck_in_o;
  int          error_cnt = 0, checks_done = 0, seed = 32'h2ccbf4b2;
  int          m_pdir, m_pdat, m_sdir, m_sdat, m_txs, m_ctl, oe, o, lvl;
  // clock
  always #5 core_clk_i = ~core_clk_i;
  ////////////////////////////////////////////////////////////////////////////////
  port_gpio DUT (
    .core_clk_i(core_clk_i), .nrst_i(nrst_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i),
    .pready_o(pready_o), .prdata_o(prdata_o), .pslverr_o(pslverr_o),
    .plain_pin_i(plain_pin_i), .plain_pin_o(plain_pin_o), .plain_pin_oe_o(plain_pin_oe_o),
    .shared_pin_i(shared_pin_i), .shared_pin_o(shared_pin_o),
    .shared_pin_oe_o(shared_pin_oe_o), .ser_txd_i(ser_txd_i), .ser_sck_out_i(ser_sck_out_i),
    .ser_rxd_o(ser_rxd_o), .ser_sck_in_o(ser_sck_in_o)
  );
  pin_board u_board (
    .p_oe_i(plain_pin_oe_o), .p_o_i(plain_pin_o), .p_ext_i(p_ext), .s_oe_i(shared_pin_oe_o),
    .s_o_i(shared_pin_o), .s_ext_i(s_ext), .p_lvl_o(plain_pin_i), .s_lvl_o(shared_pin_i)
  );
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      error_cnt++;
    end
  endtask
  task automatic results();
    $display("errors %0d checks %0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // one apb transfer, waiting for pready under a bound
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int n;
    @(posedge core_clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge core_clk_i);
    penable_i <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 16);
    if (pready_o !== 1'b1) begin
      error_cnt++;
      results();
    end
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  // model of pin functions compared with the pins and reads
  task automatic check_all();
    int rx_on, ck1, cko, fn;
    repeat (5) @(posedge core_clk_i);
    rx_on = m_ctl & 1;
    ck1 = (m_ctl >> 2) & 1;
    cko = !ck1 && (m_ctl & 4'ha) != 0;
    oe = (m_sdir & 5'h18) | ((m_txs ? 4 : 0) | (m_sdir & 4)) | (rx_on ? 0 : m_sdir & 2);
    oe = oe | (ck1 ? 0 : (cko ? 1 : m_sdir & 1));
    o = m_sdat;
    if (m_txs) o = (o & 5'h1b) | (ser_txd_i << 2);
    if (cko) o = (o & 5'h1e) | ser_sck_out_i;
    lvl = (oe & o) | (~oe & s_ext);
    chk("plain oe", plain_pin_oe_o, m_pdir);
    chk("plain out", plain_pin_o, m_pdat);
    chk("shared oe", shared_pin_oe_o, oe);
    chk("shared out", shared_pin_o & oe, o & oe);
    chk("rxd", ser_rxd_o, rx_on ? (lvl >> 1) & 1 : 0);
    chk("sck in", ser_sck_in_o, ck1 ? lvl & 1 : 0);
    apb(1'b0, 32'h004, 32'h0);
    chk("plain read", rd, (m_pdat & m_pdir) | (p_ext & ~m_pdir));
    apb(1'b0, 32'h00c, 32'h0);
    chk("shared read", rd, 32'he0 | (lvl & 5'h1f));
    apb(1'b0, 32'h010, 32'h0);
    chk("pin mode read", rd, m_txs << 1);
    apb(1'b0, 32'h014, 32'h0);
    chk("serial control read", rd, m_ctl);
    fn = (m_txs << 4) | (rx_on << 3) | (ck1 << 2) | (cko << 1);
    fn = fn | ((m_ctl & 4'he) == 0);
    apb(1'b0, 32'h018, 32'h0);
    chk("pin function read", rd, fn);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {m_pdir, m_pdat, m_sdir, m_sdat, m_txs, m_ctl} = 192'h0;
    repeat (6) @(posedge core_clk_i);
    nrst_i <= 1'b1;
    p_ext <= 8'($random(seed));
    s_ext <= 5'($random(seed));
    check_all();
    for (int i = 0; i < 34; i++) begin
      m_pdir = $random(seed) & 8'hff;
      m_pdat = $random(seed) & 8'hff;
      m_sdir = $random(seed) & 5'h1f;
      m_sdat = $random(seed) & 5'h1f;
      m_ctl = i % 16;
      m_txs = (i >> 4) & 1;
      apb(1'b1, 32'h000, m_pdir);
      apb(1'b1, 32'h004, m_pdat);
      apb(1'b1, 32'h008, m_sdir);
      apb(1'b1, 32'h00c, m_sdat);
      apb(1'b1, 32'h010, m_txs << 1);
      apb(1'b1, 32'h014, m_ctl);
      p_ext <= 8'($random(seed));
      s_ext <= 5'($random(seed));
      ser_txd_i <= 1'($random(seed));
      ser_sck_out_i <= 1'($random(seed));
      check_all();
    end
    // refused and ignored accesses
    apb(1'b0, 32'h01c, 32'h0);
    chk("unmapped err", err, 1);
    chk("unmapped data", rd, 0);
    apb(1'b0, 32'h1004, 32'h0);
    chk("high address err", err, 1);
    apb(1'b1, 32'h018, 32'h1f);
    chk("status write err", err, 1);
    pstrb_i <= 4'he;
    apb(1'b1, 32'h000, ~m_pdir);
    pstrb_i <= 4'hf;
    apb(1'b0, 32'h000, 32'h0);
    chk("direction read", rd, 0);
    apb(1'b0, 32'h008, 32'h0);
    chk("shared direction read", rd, 0);
    check_all();
    // second reset in mid-run
    nrst_i <= 1'b0;
    repeat (2) @(posedge core_clk_i);
    nrst_i <= 1'b1;
    {m_pdir, m_pdat, m_sdir, m_sdat, m_txs, m_ctl} = 192'h0;
    check_all();
    results();
  end
endmodule // serial_shared_port_and_gpio_port_tb
